// *** verif/mdu_cpu.sv ***
`timescale 1ns/1ps
module mdu_cpu
(
   // Clock and slave answer
   input wire logic clk,
   input wire logic [31:0] din,
   input wire logic ack,
   input wire logic err,
   // Request
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [4:0] adr,
   output logic [3:0] sel,
   output logic [31:0] dout
);
   initial {cyc, stb, we, adr, sel, dout} = '0;
   task acc(input logic w, input logic [4:0] a, input logic [3:0] s,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clk);
      {cyc, stb, we, adr, sel, dout} <= {2'b11, w, a, s, d};
      do @(posedge clk); while (!(ack || err));
      q = din;
      e = err;
      {cyc, stb, we} <= 3'b000;
      dout <= ~d; // Released data must not linger
   endtask : acc
endmodule : mdu_cpu

// *** verif/mdu_regs_chk.sv ***
`timescale 1ns/1ps
module mdu_regs_chk
(
   // Clock, reset and clock enable
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   // Bus and status
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [4:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic WB_ERR_O,
   input wire logic BUSY
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   // Request accepted this edge
   wire tk = WB_CYC_I && WB_STB_I && CLK_EN && !WB_ACK_O && !WB_ERR_O;
   wire mapd = WB_ADR_I <= 5'h14 && WB_ADR_I[1:0] == 2'h0;
   wire rdk = WB_ACK_O && !WB_WE_I;
   AST_ACK_LATENCY:
   assert property (tk && mapd |=> WB_ACK_O && !WB_ERR_O) else $error("ack missing");
   AST_ERR_UNMAPPED:
   assert property (tk && !mapd |=> WB_ERR_O && !WB_ACK_O) else $error("err missing");
   AST_ACK_PULSE:
   assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
   AST_IDLE_SILENT:
   assert property (!WB_STB_I |=> !WB_ACK_O && !WB_ERR_O) else $error("answer unasked");
   AST_DATA_QUIET:
   assert property (!rdk |-> WB_DAT_O == 32'h0000_0000) else $error("data not zero");
   AST_WORD_UPPER:
   assert property (rdk |-> WB_DAT_O[31:16] == 16'h0000) else $error("upper half set");
   AST_CTRL_UPPER:
   assert property (rdk && WB_ADR_I == 5'h08 |-> WB_DAT_O[15:8] == 8'h00)
      else $error("control upper byte set");
   AST_CMD_BUSY:
   assert property (tk && WB_WE_I && WB_ADR_I == 5'h10 && WB_SEL_I[0] && !BUSY
      |-> ##[1:3] BUSY)
      else $error("command did not start");
   AST_BUSY_BOUND:
   assert property ($rose(BUSY) |-> ##[1:20] !BUSY) else $error("busy too long");
   cover property (tk && WB_ADR_I == 5'h10);
   cover property ($fell(BUSY));
   cover property (WB_ERR_O);
endmodule : mdu_regs_chk
bind mdu_regs mdu_regs_chk mdu_regs_chk_inst (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
   .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
   .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .WB_ERR_O(WB_ERR_O), .BUSY(BUSY));

// *** verif/mdu_regs_test.sv ***
`timescale 1ns/1ps
module mdu_regs_test;
   import mdu_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic cyc, stb, we, ack, err, busy, e;
   logic [4:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_i, dat_o, q;
   int miscompares = 0;
   int checks = 0;
   always #25 clock = ~clock;
   mdu_regs mdu_regs_inst (.CLOCK(clock), .SYS_RST(sys_rst), .CLK_EN(clk_en),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
      .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .WB_ERR_O(err), .BUSY(busy));
   mdu_cpu mdu_cpu_inst (.clk(clock), .din(dat_o), .ack(ack), .err(err), .cyc(cyc),
      .stb(stb), .we(we), .adr(adr), .sel(sel), .dout(dat_i));
   task end_sim;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x)
      begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   task wr(input logic [4:0] a, input logic [31:0] d);
      mdu_cpu_inst.acc(1'b1, a, 4'hF, d, q, e);
   endtask : wr
   task rd(input logic [4:0] a, input logic [31:0] x);
      mdu_cpu_inst.acc(1'b0, a, 4'hF, 32'h0000_0000, q, e);
      chk(q, x);
   endtask : rd
   task riu(input logic b);
      mdu_cpu_inst.acc(1'b0, 5'h08, 4'hF, 32'h0000_0000, q, e);
      chk(q & 32'hFFFF_FF10, {27'h0, b, 4'h0});
   endtask : riu
   task op(input logic [1:0] c, input logic [15:0] h, l, o, xh, xl);
      wr(5'h00, {16'h0, h});
      wr(5'h04, {16'h0, l});
      wr(5'h0C, {16'h0, o});
      rd(5'h04, {16'h0, l});
      wr(5'h10, {30'h0, c});
      repeat (20) @(posedge clock);
      rd(5'h14, 32'h0000_0000);
      riu(1'b1);
      rd(5'h00, {16'h0, xh});
      rd(5'h04, {16'h0, xl});
   endtask : op
   task t_reset;
      rd(5'h00, 32'h0000_0000);
      rd(5'h08, 32'h0000_0000);
      rd(5'h04, 32'h0000_0000);
      rd(5'h14, 32'h0000_0000);
      mdu_cpu_inst.acc(1'b0, 5'h18, 4'hF, 32'h0000_0000, q, e);
      chk({31'h0, e}, 32'h0000_0001);
      $display("t_reset done");
   endtask : t_reset
   task t_riu;
      wr(5'h00, 32'h0000_1234);
      riu(1'b1);
      rd(5'h00, 32'h0000_1234);
      riu(1'b1);
      rd(5'h04, 32'h0000_0000);
      riu(1'b0);
      wr(5'h04, 32'h0000_ABCD);
      riu(1'b1);
      mdu_cpu_inst.acc(1'b1, 5'h04, 4'h1, 32'h0000_5555, q, e);
      rd(5'h04, 32'h0000_ABCD);
      $display("t_riu done");
   endtask : t_riu
   task t_ctrl;
      logic [31:0] sc, sh, sl;
      mdu_cpu_inst.acc(1'b0, 5'h08, 4'hF, 32'h0000_0000, sc, e);
      chk(sc & 32'hFFFF_FF00, 32'h0000_0000);
      mdu_cpu_inst.acc(1'b0, 5'h00, 4'hF, 32'h0000_0000, sh, e);
      mdu_cpu_inst.acc(1'b0, 5'h04, 4'hF, 32'h0000_0000, sl, e);
      wr(5'h08, 32'h0000_0000);
      rd(5'h08, 32'h0000_0000);
      op(2'h1, 16'h0000, 16'h0100, 16'h0100, 16'h0001, 16'h0000);
      wr(5'h00, sh);
      wr(5'h04, sl);
      wr(5'h08, {16'hFFFF, 8'hFF, sc[7:0]});
      rd(5'h08, sc);
      rd(5'h00, sh);
      rd(5'h04, sl);
      $display("t_ctrl done");
   endtask : t_ctrl
   task t_mul;
      op(2'h0, 16'h7777, 16'hFFFE, 16'h0003, 16'hFFFF, 16'hFFFA);
      op(2'h1, 16'h7777, 16'hFFFE, 16'h0003, 16'h0002, 16'hFFFA);
      $display("t_mul done");
   endtask : t_mul
   task t_div;
      op(2'h3, 16'h0001, 16'h0005, 16'h0010, 16'h0005, 16'h1000);
      op(2'h2, 16'hFFFF, 16'hFFF9, 16'h0002, 16'hFFFF, 16'hFFFD);
      op(2'h2, 16'h0000, 16'h0007, 16'hFFFE, 16'h0001, 16'hFFFD);
      wr(5'h00, 32'h0000_0000);
      wr(5'h04, 32'h0000_0064);
      wr(5'h0C, 32'h0000_0007);
      wr(5'h10, 32'h0000_0003);
      clk_en <= 1'b0;
      repeat (3) @(posedge clock);
      clk_en <= 1'b1;
      @(negedge clock);
      chk({31'h0, busy}, 32'h0000_0001);
      repeat (20) @(posedge clock);
      rd(5'h00, 32'h0000_0002);
      rd(5'h04, 32'h0000_000E);
      $display("t_div done");
   endtask : t_div
   initial
   begin
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      t_reset;
      t_riu;
      t_mul;
      t_ctrl;
      t_div;
      end_sim;
   end
   initial
   begin
      repeat (5000) @(posedge clock);
      miscompares++;
      $display("ERROR %0t: watchdog expired", $time);
      end_sim;
   end
endmodule : mdu_regs_test

// *** verilog/mdu_divstep.sv ***
`timescale 1ns/1ps
module mdu_divstep
(
   // Partial remainder, quotient, divisor
   input wire logic [15:0] rem,
   input wire logic [15:0] quo,
   input wire logic [15:0] dvs,
   // Next partial values
   output logic [15:0] rem_o,
   output logic [15:0] quo_o
);
   logic [16:0] sh;
   logic [16:0] df;
   assign sh = {rem, quo[15]};
   assign df = sh - {1'b0, dvs};
   assign rem_o = df[16] ? sh[15:0] : df[15:0];
   assign quo_o = {quo[14:0], ~df[16]};
endmodule : mdu_divstep

// *** verilog/mdu_map.svh ***
`ifndef MDU_MAP_SVH
`define MDU_MAP_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define MDU_OFS_HIGH 4'h0
`define MDU_OFS_LOW 4'h4
`define MDU_OFS_CTRL 4'h8
`define MDU_OFS_OPER 4'hC
`define MDU_OFS_CMD 5'h10
`define MDU_OFS_STAT 5'h14
// ****************************************
// Field positions, reset values, divide step count and command codes
// ****************************************
`define MDU_RIU_BIT 4
`define MDU_CTRL_USED_MASK 16'h00FF
`define MDU_RESET_WORD 16'h0000
`define MDU_DIV_STEPS 5'h10
`define MDU_CMD_MUL 2'h0
`define MDU_CMD_MULU 2'h1
`define MDU_CMD_DIVL 2'h2
`define MDU_CMD_DIVLU 2'h3
`endif

// *** verilog/mdu_mult.sv ***
`timescale 1ns/1ps
module mdu_mult
(
   // Operands
   input wire logic [15:0] a,
   input wire logic [15:0] b,
   input wire logic sgn,
   // Product
   output logic [31:0] p
);
   logic signed [32:0] sp;
   assign sp = $signed({sgn & a[15], a}) * $signed({sgn & b[15], b});
   assign p = sp[31:0];
endmodule : mdu_mult

// *** verilog/mdu_pkg.sv ***
package mdu_pkg;
   typedef logic [15:0] mdu_word_t;
   typedef enum logic [2:0]
   {
      MDU_IDLE = 3'b001,
      MDU_MUL = 3'b010,
      MDU_DIV = 3'b100
   } mdu_state_e;
endpackage : mdu_pkg

// *** verilog/mdu_regs.sv ***
`timescale 1ns/1ps
`include "mdu_map.svh"
// Contract
// RULE1 - Multiply leaves product upper half high
// RULE2 - Multiply leaves product lower half low
// RULE3 - Software loads dividend upper half first
// RULE4 - Software loads dividend lower half last
// RULE5 - Division leaves remainder in high word
// RULE6 - Division leaves quotient in low word
// RULE7 - Writing high or low sets in-use
// RULE8 - Any multiply or divide sets in-use
// RULE9 - Reading low clears in-use; high not
// RULE10 - Control updated every cycle while busy
// RULE11 - Software saves/restores status bits and both result words
// RULE12 - Interrupt code saves, clears, restores all
// RULE13 - Control bit writable, result words whole
// RULE14 - In-use bit 4, upper byte zero
module mdu_regs
(
   // Clock, reset, enable
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   // Wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [4:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   output logic WB_ERR_O,
   // Status
   output logic BUSY
);
   import mdu_pkg::*;

   // ****************************************
   // Bus decode
   // ****************************************
   mdu_word_t high_word;
   mdu_word_t low_word;
   mdu_word_t control;
   mdu_word_t operand;
   mdu_state_e state;
   logic [4:0] steps;
   logic div_neg_q;
   logic div_neg_r;
   logic op_signed;
   logic [31:0] product;
   mdu_word_t step_rem;
   mdu_word_t step_quo;
   mdu_word_t divisor;
   logic req;
   logic wr;
   logic rd;
   logic hit;
   logic wr_lo16;
   logic wr_hi_b;
   logic wr_lo_b;

   function automatic logic is_reg(input logic [4:0] a, input logic [4:0] ofs);
      is_reg = (a == ofs);
   endfunction : is_reg

   function automatic mdu_word_t mag(input mdu_word_t v, input logic neg);
      mag = neg ? mdu_word_t'(-v) : v;
   endfunction : mag

   assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O & CLK_EN;
   assign hit = is_reg(WB_ADR_I, {1'b0, `MDU_OFS_HIGH}) | is_reg(WB_ADR_I, {1'b0, `MDU_OFS_LOW})
      | is_reg(WB_ADR_I, {1'b0, `MDU_OFS_CTRL}) | is_reg(WB_ADR_I, {1'b0, `MDU_OFS_OPER})
      | is_reg(WB_ADR_I, `MDU_OFS_CMD) | is_reg(WB_ADR_I, `MDU_OFS_STAT);
   assign wr = req & hit & WB_WE_I;
   assign rd = req & hit & ~WB_WE_I;
   assign wr_hi_b = WB_SEL_I[1];
   assign wr_lo_b = WB_SEL_I[0];
   assign wr_lo16 = WB_SEL_I[1] & WB_SEL_I[0];

   // ****************************************
   // Datapath
   // ****************************************
   mdu_mult u_mult
   (
      .a(low_word),
      .b(operand),
      .sgn(op_signed),
      .p(product)
   );

   // Signed divide steps on the divisor magnitude
   assign divisor = mag(operand, op_signed & operand[15]);

   mdu_divstep u_div
   (
      .rem(high_word),
      .quo(low_word),
      .dvs(divisor),
      .rem_o(step_rem),
      .quo_o(step_quo)
   );

   // ****************************************
   // Bus answer
   // ****************************************
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         WB_ACK_O <= 1'b0;
         WB_ERR_O <= 1'b0;
      end
      else if (CLK_EN)
      begin
         WB_ACK_O <= req & hit;
         WB_ERR_O <= req & ~hit;
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         WB_DAT_O <= 32'h0000_0000;
      end
      else if (CLK_EN)
      begin
         if (rd)
         begin
            unique case (WB_ADR_I)
               {1'b0, `MDU_OFS_HIGH}: WB_DAT_O <= {16'h0000, high_word};
               {1'b0, `MDU_OFS_LOW}: WB_DAT_O <= {16'h0000, low_word};
               {1'b0, `MDU_OFS_CTRL}: WB_DAT_O <= {16'h0000, control & `MDU_CTRL_USED_MASK}; // see RULE14
               {1'b0, `MDU_OFS_OPER}: WB_DAT_O <= {16'h0000, operand};
               `MDU_OFS_STAT: WB_DAT_O <= {31'h0000_0000, state != MDU_IDLE};
               default: WB_DAT_O <= 32'h0000_0000;
            endcase
         end
         else
         begin
            WB_DAT_O <= 32'h0000_0000;
         end
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         state <= MDU_IDLE;
         steps <= 5'h00;
         op_signed <= 1'b0;
         div_neg_q <= 1'b0;
         div_neg_r <= 1'b0;
         BUSY <= 1'b0;
      end
      else if (CLK_EN)
      begin
         unique case (state)
            MDU_IDLE:
            begin
               if (wr && WB_ADR_I == `MDU_OFS_CMD && wr_lo_b)
               begin
                  op_signed <= ~WB_DAT_I[0];
                  BUSY <= 1'b1;
                  steps <= `MDU_DIV_STEPS;
                  div_neg_q <= ~WB_DAT_I[0] & (high_word[15] ^ operand[15]);
                  div_neg_r <= ~WB_DAT_I[0] & high_word[15];
                  state <= WB_DAT_I[1] ? MDU_DIV : MDU_MUL;
               end
            end
            MDU_MUL:
            begin
               state <= MDU_IDLE;
               BUSY <= 1'b0;
            end
            MDU_DIV:
            begin
               steps <= steps - 5'h01;
               if (steps == 5'h01)
               begin
                  state <= MDU_IDLE;
                  BUSY <= 1'b0;
               end
            end
         endcase
      end
   end

   // ****************************************
   // Result words
   // ****************************************
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         high_word <= `MDU_RESET_WORD;
         low_word <= `MDU_RESET_WORD;
      end
      else if (CLK_EN)
      begin
         if (state == MDU_IDLE && wr && WB_ADR_I == `MDU_OFS_CMD && wr_lo_b && WB_DAT_I[1]
            && ~WB_DAT_I[0])
         begin
            // Signed divide runs on magnitudes of 32-bit dividend low word and 16-bit divisor
            high_word <= 16'h0000;
            low_word <= mag(low_word, high_word[15]);
         end
         else if (state == MDU_MUL)
         begin
            high_word <= product[31:16]; // see RULE1
            low_word <= product[15:0]; // see RULE2
         end
         else if (state == MDU_DIV)
         begin
            if (steps == 5'h01)
            begin
               high_word <= mag(step_rem, div_neg_r); // see RULE5
               low_word <= mag(step_quo, div_neg_q); // see RULE6
            end
            else
            begin
               high_word <= step_rem;
               low_word <= step_quo;
            end
         end
         else if (wr && wr_lo16) // see RULE13
         begin
            if (WB_ADR_I == {1'b0, `MDU_OFS_HIGH})
            begin
               high_word <= WB_DAT_I[15:0];
            end
            if (WB_ADR_I == {1'b0, `MDU_OFS_LOW})
            begin
               low_word <= WB_DAT_I[15:0];
            end
         end
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         operand <= `MDU_RESET_WORD;
      end
      else if (CLK_EN && state == MDU_IDLE && wr && wr_lo16
         && WB_ADR_I == {1'b0, `MDU_OFS_OPER})
      begin
         operand <= WB_DAT_I[15:0];
      end
   end

   // ****************************************
   // Control register
   // ****************************************
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         control <= `MDU_RESET_WORD;
      end
      else if (CLK_EN)
      begin
         if (state != MDU_IDLE)
         begin
            // Progress count in low status bits, in-use held
            control <= {8'h00, steps[4], state == MDU_DIV, state == MDU_MUL, 1'b1,
               steps[3:0]}; // see RULE10, RULE8
         end
         else if (state == MDU_IDLE && wr && WB_ADR_I == `MDU_OFS_CMD && wr_lo_b)
         begin
            control[`MDU_RIU_BIT] <= 1'b1; // see RULE8
         end
         else if (wr && WB_ADR_I == {1'b0, `MDU_OFS_CTRL})
         begin
            // Byte-lane write keeps bit access to status; save and restore path
            if (wr_lo_b)
            begin
               control[7:0] <= WB_DAT_I[7:0]; // see RULE13, RULE12
            end
         end
         else if (wr && wr_lo16
            && (WB_ADR_I == {1'b0, `MDU_OFS_HIGH} || WB_ADR_I == {1'b0, `MDU_OFS_LOW}))
         begin
            control[`MDU_RIU_BIT] <= 1'b1; // see RULE7
         end
         else if (rd && WB_ADR_I == {1'b0, `MDU_OFS_LOW})
         begin
            control[`MDU_RIU_BIT] <= 1'b0; // see RULE9
         end
         control[15:8] <= 8'h00; // see RULE14
      end
   end
   // wr_hi_b unused lane for control upper byte, which is always zero
   logic unused_hi;
   assign unused_hi = wr_hi_b;
endmodule : mdu_regs
